/* verilog/alu_ctrl_pkg.sv */
// Package for the ALU and shifter control block: field codes, control
// encodings, register offsets, field positions and reset values.
// Assumes a 32-bit classic Wishbone register port with byte addressing.
package alu_ctrl_pkg;

    // Microword ALU control field codes
    localparam logic [2:0] CODE_NOT_A = 3'h0;
    localparam logic [2:0] CODE_B = 3'h1;
    localparam logic [2:0] CODE_A = 3'h2;
    localparam logic [2:0] CODE_A_PLUS_B = 3'h3;
    localparam logic [2:0] CODE_UNUSED = 3'h4;
    localparam logic [2:0] CODE_A_PLUS_A = 3'h5;
    localparam logic [2:0] CODE_A_MINUS_B = 3'h6;
    localparam logic [2:0] CODE_INSTR_DEP = 3'h7;

    // Function selects S3..S0 at the ALU, high = H
    localparam logic [3:0] SEL_NOT_A = 4'h0;
    localparam logic [3:0] SEL_B = 4'ha;
    localparam logic [3:0] SEL_A = 4'h0;
    localparam logic [3:0] SEL_A_PLUS_B = 4'h9;
    localparam logic [3:0] SEL_A_PLUS_A = 4'hc;
    localparam logic [3:0] SEL_A_MINUS_B = 4'h6;

    // Mode: high selects logic functions, low selects arithmetic
    localparam logic MODE_LOGIC = 1'b1;
    localparam logic MODE_ARITH = 1'b0;

    // Shifter select level that picks the byte-swapped input
    localparam logic [1:0] SHIFT_SWAP = 2'h0;

    // Register offsets (byte addresses)
    localparam logic [3:0] REG_UNUSED_FILL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;

    // Unused-code fill register fields
    localparam int FILL_SEL_LSB = 0;
    localparam int FILL_MODE_BIT = 4;
    localparam int FILL_CARRY_BIT = 5;
    localparam logic [5:0] FILL_RESET = 6'h10;

    // Status register fields
    localparam int STAT_ZERO_BIT = 0;
    localparam int STAT_LEFT_SAVE_BIT = 1;
    localparam int STAT_ODD_DEST_BIT = 2;
    localparam int STAT_INSTR_DEP_BIT = 3;
    localparam int STAT_SEL_LSB = 4;
    localparam int STAT_MODE_BIT = 8;
    localparam int STAT_CARRY_BIT = 9;
    localparam int STAT_SHIFT_LSB = 10;

    // Reset values of the held flags
    localparam logic ZERO_RESET = 1'b0;
    localparam logic LEFT_SAVE_RESET = 1'b0;
    localparam logic ODD_DEST_RESET = 1'b0;

endpackage

/* verilog/alu_shifter_control_zero_detect.sv */
// ALU function, mode and carry-in control, shifter select control,
// shifter zero detection, divide left-save and odd-byte destination flags.
// Assumes all decode, microword and timing inputs are synchronous to clock;
// the subsidiary control ROM outputs arrive already indexed by the opcode.
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/100ps

// Overview of operation
// - Select high routes microword ALU and shifter fields through the two-way mux.
// - ALU field 7 asserts instruction-dependent select; all controls come from ROM.
// - Decode 3-bit ALU field with flags and decode into six ALU controls.
// - Codes 0 not A, 1 B, 2 A, 6 A minus B; code 4 unused.
// - Code 3 gives A plus B: selects H,L,L,H, arithmetic, carry low.
// - Code 5 gives A plus A: selects H,H,L,L, arithmetic, carry low.
// - Instruction-dependent: each control from its ROM bit; selects 0,1 pass unchanged.
// - Swap-bytes blocks function selects 2 and 3 of the shared shift-left word.
// - Mode from ROM, except sign-extend with sign set forces arithmetic (minus 1).
// - Rotate-left, add-carry, subtract-carry force arithmetic mode for A plus A.
// - ROM mode and ROM carry together request data-dependent carry-in.
// - Two-word left shift of divide/shift-combined takes carry from low word MSB.
// - Data carry: add-carry, rotate-left on carry set; subtract-carry on carry clear.
// - Assert byte-move sign-extend while a move-byte instruction executes.
// - Give high-byte-significant indication in both polarities.
// - Shifter selects from microword, or from ROM when instruction-dependent.
// - Swap-bytes or needed byte swap forces both shifter selects low.
// - Zero test needs whole word for words, low byte for normal bytes.
// - Odd-byte operations and swap-bytes test only the shifter high byte.
// - Two-word check clears zero if second word nonzero, else keeps it.
// - During divide, left-save captures ALU carry-out after each subtract cycle.
// - Odd-byte destination loads with destination register, same input bit.
// - Left shifts use the A plus A function to double the operand.
module alu_shifter_control_zero_detect
    import alu_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Microword fields
    input wire logic [2:0] ucodeAluField,
    input wire logic [1:0] ucodeShiftField,
    // Subsidiary control ROM outputs
    input wire logic [3:0] subromSelectOut,
    input wire logic subromModeOut,
    input wire logic subromCarryOut,
    input wire logic [1:0] subromShiftOut,
    // Instruction decode and condition codes
    input wire logic swapBytesInstr,
    input wire logic signExtendInstr,
    input wire logic rotateLeftInstr,
    input wire logic addCarryInstr,
    input wire logic subtractCarryInstr,
    input wire logic divideInstr,
    input wire logic arithShiftCombinedInstr,
    input wire logic moveByteInstr,
    input wire logic byteSwapNeeded,
    input wire logic byteOperation,
    input wire logic oddByteOperation,
    input wire logic twoWordShiftState,
    input wire logic carryFlag,
    input wire logic signBit,
    input wire logic lowWordMsb,
    // Datapath feedback
    input wire logic [15:0] resultShifter,
    input wire logic aluCarryOut,
    input wire logic subtractCycle,
    input wire logic zeroUpdate,
    input wire logic secondWordZeroCheck,
    input wire logic destRegClock,
    input wire logic destRegLoad,
    input wire logic destLoadBit,
    // Controls to the datapath
    output logic instrDependentSelectN,
    output logic [3:0] aluFunctionSelectN,
    output logic aluLogicModeN,
    output logic aluCarryIn,
    output logic [1:0] shifterSelectN,
    output logic byteMoveSignExtend,
    output logic highByteSignificant,
    output logic highByteSignificantN,
    output logic resultZeroN,
    output logic zeroFlag,
    output logic divideLeftSave,
    output logic oddByteDestination
);

    // Fixed levels for the unused field code, held in a software register
    logic [5:0] unusedFill_q;
    logic [5:0] unusedFill_d;
    logic zero_q;
    logic zero_d;
    logic leftSave_q;
    logic leftSave_d;
    logic oddDest_q;
    logic oddDest_d;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic instrDep_q;
    logic [3:0] sel_q;
    logic mode_q;
    logic carry_q;
    logic [1:0] shift_q;
    logic signExt_q;
    logic highSig_q;
    logic zeroDet_q;

    // ---------------- Microword decode ----------------
    logic [3:0] uSel;
    logic uMode;
    logic uCarry;

    always_comb begin
        uSel = SEL_A;
        uMode = MODE_ARITH;
        uCarry = 1'b0;
        case (ucodeAluField)
            CODE_NOT_A: begin
                uSel = SEL_NOT_A;
                uMode = MODE_LOGIC;
            end
            CODE_B: begin
                uSel = SEL_B;
                uMode = MODE_LOGIC;
            end
            CODE_A: begin
                uSel = SEL_A;
                uMode = MODE_ARITH;
            end
            CODE_A_PLUS_B: begin
                uSel = SEL_A_PLUS_B;
                uMode = MODE_ARITH;
            end
            CODE_A_PLUS_A: begin
                // Doubling the operand is the one-bit left shift
                uSel = SEL_A_PLUS_A;
                uMode = MODE_ARITH;
            end
            CODE_A_MINUS_B: begin
                uSel = SEL_A_MINUS_B;
                uMode = MODE_ARITH;
                uCarry = 1'b1;
            end
            CODE_UNUSED: begin
                uSel = unusedFill_q[FILL_SEL_LSB +: 4];
                uMode = unusedFill_q[FILL_MODE_BIT];
                uCarry = unusedFill_q[FILL_CARRY_BIT];
            end
            default: begin
                uSel = SEL_A;
                uMode = MODE_ARITH;
                uCarry = 1'b0;
            end
        endcase
    end

    // ---------------- Instruction-dependent path ----------------
    wire instrDep = (ucodeAluField == CODE_INSTR_DEP);
    // Swap reuses the shift-left word with the upper selects blocked
    wire [3:0] romSel = {subromSelectOut[3:2] & {2{~swapBytesInstr}},
                         subromSelectOut[1:0]};
    wire forceArith = (signExtendInstr & signBit) | rotateLeftInstr
                      | addCarryInstr | subtractCarryInstr;
    wire romMode = forceArith ? MODE_ARITH : subromModeOut;
    wire dataCarryReq = subromModeOut & subromCarryOut;
    wire dataCarry = ((addCarryInstr | rotateLeftInstr) & carryFlag)
                     | (subtractCarryInstr & ~carryFlag);
    wire twoWordShift = twoWordShiftState & (divideInstr | arithShiftCombinedInstr);
    wire romCarry = twoWordShift ? lowWordMsb
                  : dataCarryReq ? dataCarry
                  : subromCarryOut;

    // Two-way selection, microword when select line is high
    wire [3:0] selNext = instrDep ? romSel : uSel;
    wire modeNext = instrDep ? romMode : uMode;
    wire carryNext = instrDep ? romCarry : uCarry;
    wire [1:0] shiftRaw = instrDep ? subromShiftOut : ucodeShiftField;
    wire [1:0] shiftNext = (swapBytesInstr | byteSwapNeeded) ? SHIFT_SWAP
                           : shiftRaw;

    // ---------------- Byte significance and zero detection ----------------
    wire highOnly = oddByteOperation | swapBytesInstr;
    wire highSigNext = ~byteOperation | highOnly;
    wire lowZero = (resultShifter[7:0] == 8'h00);
    wire highZero = (resultShifter[15:8] == 8'h00);
    wire dataZero = highOnly ? highZero
                  : byteOperation ? lowZero
                  : (lowZero & highZero);

    // Second word may only clear the flag, never set it
    assign zero_d = ~zeroUpdate ? zero_q
                  : secondWordZeroCheck ? (zero_q & dataZero)
                  : dataZero;
    assign leftSave_d = (divideInstr & subtractCycle) ? aluCarryOut : leftSave_q;
    assign oddDest_d = (destRegClock & destRegLoad) ? destLoadBit : oddDest_q;

    // Controls are registered once per machine cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            instrDep_q <= 1'b0;
            sel_q <= SEL_A;
            mode_q <= MODE_ARITH;
            carry_q <= 1'b0;
            shift_q <= SHIFT_SWAP;
            signExt_q <= 1'b0;
            highSig_q <= 1'b0;
            zeroDet_q <= 1'b0;
        end else begin
            instrDep_q <= instrDep;
            sel_q <= selNext;
            mode_q <= modeNext;
            carry_q <= carryNext;
            shift_q <= shiftNext;
            signExt_q <= moveByteInstr;
            highSig_q <= highSigNext;
            zeroDet_q <= dataZero;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= ZERO_RESET;
            leftSave_q <= LEFT_SAVE_RESET;
            oddDest_q <= ODD_DEST_RESET;
        end else begin
            zero_q <= zero_d;
            leftSave_q <= leftSave_d;
            oddDest_q <= oddDest_d;
        end
    end

    assign instrDependentSelectN = ~instrDep_q;
    assign aluFunctionSelectN = ~sel_q;
    assign aluLogicModeN = ~mode_q;
    assign aluCarryIn = carry_q;
    assign shifterSelectN = shift_q;
    assign byteMoveSignExtend = signExt_q;
    assign highByteSignificant = highSig_q;
    assign highByteSignificantN = ~highSig_q;
    assign resultZeroN = ~zeroDet_q;
    assign zeroFlag = zero_q;
    assign divideLeftSave = leftSave_q;
    assign oddByteDestination = oddDest_q;

    // ---------------- Wishbone slave ----------------
    wire access = cyc_i & stb_i & ~ack_q;
    wire hitFill = (adr_i == REG_UNUSED_FILL);
    wire hitStatus = (adr_i == REG_STATUS);
    wire fillWrite = access & we_i & hitFill & sel_i[0];

    wire [31:0] statusWord = {20'h00000,
                              shift_q,
                              carry_q,
                              mode_q,
                              sel_q,
                              instrDep_q,
                              oddDest_q,
                              leftSave_q,
                              zero_q};
    wire [31:0] fillWord = {26'h0000000, unusedFill_q};

    assign unusedFill_d = fillWrite ? dat_i[5:0] : unusedFill_q;
    // Unmapped addresses read zero and ignore writes, but still acknowledge
    assign rdata_d = ~access ? rdata_q
                   : hitFill ? fillWord
                   : hitStatus ? statusWord
                   : 32'h00000000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            unusedFill_q <= FILL_RESET;
        end else begin
            ack_q <= access;
            rdata_q <= rdata_d;
            unusedFill_q <= unusedFill_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdata_q;

endmodule

/* testbench/alu_ctrl_asserts.sv */
// Port checks for the ALU and shifter control block.
// Assumes every control output follows the inputs of the previous edge.
`timescale 1ns/100ps
module alu_ctrl_asserts
    import alu_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [2:0] ucodeAluField,
    input wire logic swapBytesInstr,
    input wire logic byteSwapNeeded,
    input wire logic byteOperation,
    input wire logic oddByteOperation,
    input wire logic divideInstr,
    input wire logic subtractCycle,
    input wire logic aluCarryOut,
    input wire logic [15:0] resultShifter,
    input wire logic zeroUpdate,
    input wire logic secondWordZeroCheck,
    input wire logic instrDependentSelectN,
    input wire logic [3:0] aluFunctionSelectN,
    input wire logic aluLogicModeN,
    input wire logic aluCarryIn,
    input wire logic [1:0] shifterSelectN,
    input wire logic highByteSignificant,
    input wire logic highByteSignificantN,
    input wire logic zeroFlag,
    input wire logic divideLeftSave
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence subtractStep;
        divideInstr && subtractCycle;
    endsequence
    // A nonzero second word may only clear the flag
    sequence secondWordNonzero;
        zeroUpdate && secondWordZeroCheck && !byteOperation && !oddByteOperation
            && !swapBytesInstr && resultShifter != 16'h0;
    endsequence
    chk_dep_select: assert property (ucodeAluField == CODE_INSTR_DEP |=> !instrDependentSelectN)
        else $error("dependent select missing");
    chk_add_code: assert property (ucodeAluField == CODE_A_PLUS_B |=>
        aluFunctionSelectN == ~SEL_A_PLUS_B && aluLogicModeN == ~MODE_ARITH && !aluCarryIn)
        else $error("add code wrong");
    chk_double_code: assert property (ucodeAluField == CODE_A_PLUS_A |=>
        aluFunctionSelectN == ~SEL_A_PLUS_A && aluLogicModeN == ~MODE_ARITH && !aluCarryIn)
        else $error("double code wrong");
    chk_swap_select: assert property (ucodeAluField == 3'h7 && swapBytesInstr |=>
        aluFunctionSelectN[3:2] == 2'h3) else $error("swap selects not blocked");
    chk_swap_shift: assert property (byteSwapNeeded || swapBytesInstr |=>
        shifterSelectN == SHIFT_SWAP) else $error("shifter not swapped");
    chk_high_byte: assert property (!byteOperation |=>
        highByteSignificant && !highByteSignificantN) else $error("high byte flag wrong");
    chk_left_save: assert property (subtractStep |=> divideLeftSave == $past(aluCarryOut))
        else $error("left save missed carry");
    chk_zero_clear: assert property (secondWordNonzero |=> !zeroFlag)
        else $error("zero not cleared");
endmodule
bind alu_shifter_control_zero_detect alu_ctrl_asserts i_alu_ctrl_asserts (.*);

/* testbench/shifter_datapath_model.sv */
// Datapath stand-in: shifter output and ALU carry seen by the control block.
// Assumes the bench supplies the ALU result as operand.
`timescale 1ns/100ps
module shifter_datapath_model (
    input wire logic [15:0] operand,
    input wire logic [1:0] shifterSelectN,
    output logic [15:0] resultShifter,
    output logic aluCarryOut
);
    // Both selects low pick the byte-swapped input
    assign resultShifter = (shifterSelectN == 2'h0) ? {operand[7:0], operand[15:8]} : operand;
    // A plus A shifts left, so the carry is the old top bit
    assign aluCarryOut = operand[15];
endmodule

/* testbench/tb.sv */
// Bench for the ALU and shifter control block.
// Assumes one-cycle registered controls and a one-cycle Wishbone ack.
`timescale 1ns/100ps
module tb;
    import alu_ctrl_pkg::*;
    logic clock = 1'h0, rst_n = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic [3:0] adr_i = 4'h0, sel_i = 4'hf, subromSelectOut = 4'hf, aluFunctionSelectN;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic [2:0] ucodeAluField = 3'h0, byteIn = 3'h0;
    logic [1:0] ucodeShiftField = 2'h1, subromShiftOut = 2'h2, shifterSelectN;
    logic [11:0] ctlIn = 12'h0;
    logic [5:0] flagIn = 6'h0;
    logic [15:0] operand = 16'h0, resultShifter;
    logic ack_o, aluCarryOut, instrDependentSelectN, aluLogicModeN, aluCarryIn, zeroFlag;
    logic byteMoveSignExtend, highByteSignificant, highByteSignificantN, resultZeroN;
    logic divideLeftSave, oddByteDestination;
    logic arithShiftCombinedInstr = 1'h0, byteSwapNeeded = 1'h0;
    wire subromModeOut, subromCarryOut, swapBytesInstr, signExtendInstr, signBit;
    wire rotateLeftInstr, addCarryInstr, subtractCarryInstr, divideInstr, twoWordShiftState;
    wire carryFlag, lowWordMsb, byteOperation, oddByteOperation, moveByteInstr;
    wire zeroUpdate, secondWordZeroCheck, subtractCycle, destRegClock, destRegLoad, destLoadBit;
    wire [8:0] ctlView = {instrDependentSelectN, ~aluFunctionSelectN, ~aluLogicModeN, aluCarryIn,
        shifterSelectN};
    wire [3:0] byteView = {resultZeroN, highByteSignificant, highByteSignificantN,
        byteMoveSignExtend};
    wire [2:0] flagView = {zeroFlag, divideLeftSave, oddByteDestination};
    int failCount = 0, numChecks = 0, cycles = 0;
    localparam logic [8:0] CODE_EXP [7] = '{9'h109, 9'h1a9, 9'h101, 9'h191, 9'h109, 9'h1c1,
        9'h165};
    localparam logic [11:0] ROM_IN [10] = '{12'h800, 12'ha00, 12'h980, 12'hc42, 12'hc20,
        12'hc10, 12'hc12, 12'h00d, 12'h40c, 12'h400};
    localparam logic [8:0] ROM_EXP [10] = '{9'h0fa, 9'h038, 9'h0f2, 9'h0f6, 9'h0f2, 9'h0f6,
        9'h0f2, 9'h0f6, 9'h0f2, 9'h0f6};
    localparam logic [2:0] BYTE_IN [3] = '{3'h0, 3'h5, 3'h6};
    localparam logic [3:0] BYTE_EXP [3] = '{4'hc, 4'h3, 4'hc};
    // Each entry: update, check, divide, subtract, dest clock, dest load, dest bit, operand
    localparam logic [22:0] FLAG_IN [5] = '{{7'h5f, 16'h0}, {7'h7c, 16'h8005}, {7'h52, 16'h0},
        {7'h6e, 16'h0}, {7'h18, 16'h7}};
    localparam logic [2:0] FLAG_EXP [5] = '{3'h5, 3'h3, 3'h7, 3'h6, 3'h4};
    assign {subromModeOut, subromCarryOut, swapBytesInstr, signExtendInstr, signBit,
        rotateLeftInstr, addCarryInstr, subtractCarryInstr, divideInstr, twoWordShiftState,
        carryFlag, lowWordMsb} = ctlIn;
    assign {byteOperation, oddByteOperation, moveByteInstr} = byteIn;
    assign {zeroUpdate, secondWordZeroCheck, subtractCycle, destRegClock, destRegLoad,
        destLoadBit} = flagIn;
    alu_shifter_control_zero_detect i_alu_shifter_control_zero_detect (.*);
    shifter_datapath_model i_shifter_datapath_model (.*);
    always #10 clock = ~clock;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            failCount++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step();
        @(posedge clock);
        #1;
    endtask
    task automatic ctl(input logic [2:0] code, input logic [11:0] f, input logic [8:0] e);
        @(posedge clock);
        ucodeAluField <= code;
        ctlIn <= f;
        step();
        check(32'(ctlView), 32'(e));
    endtask
    // Classic single cycle; waits for ack, then drops the request
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack_o !== 1'h1 && n < 50);
        if (n >= 50) begin
            failCount++;
        end
        q = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
    endtask
    initial begin
        // A real falling edge, so the asynchronous reset branch runs at time zero
        rst_n <= 1'h0;
        #1;
        check(32'({ack_o, aluFunctionSelectN}), 32'h0f);
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        for (int c = 0; c < 7; c++) begin
            ctl(3'(c), 12'h0, CODE_EXP[c]);
        end
        for (int i = 0; i < 10; i++) begin
            ctl(CODE_INSTR_DEP, ROM_IN[i], ROM_EXP[i]);
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge clock);
            operand <= 16'h0100;
            byteIn <= BYTE_IN[m];
            step();
            check(32'(byteView), 32'(BYTE_EXP[m]));
        end
        for (int s = 0; s < 5; s++) begin
            @(posedge clock);
            byteIn <= 3'h0;
            {flagIn, operand} <= {FLAG_IN[s][22:21], FLAG_IN[s][19:0]};
            ctlIn <= {8'h0, FLAG_IN[s][20], 3'h0};
            step();
            check(32'(flagView), 32'(FLAG_EXP[s]));
        end
        wb(1'h1, REG_UNUSED_FILL, 32'h29, rd);
        ctl(CODE_UNUSED, 12'h0, 9'h195);
        wb(1'h0, REG_UNUSED_FILL, 32'h0, rd);
        check(rd, 32'h29);
        wb(1'h0, 4'h8, 32'h0, rd);
        check(rd, 32'h0);
        // Code 4 with fill 0x29, zero flag still set from the flag tests
        wb(1'h0, REG_STATUS, 32'h0, rd);
        check(rd, 32'h691);
        end_sim();
    end
endmodule
